// ---- src/bslc_clr_mem.sv ----
`timescale 1ns/10ps
// Loader scratch memory; a sweep port writes zeros over it on exit.
module bslc_clr_mem (
  // Clock and control
  input  wire logic                          clock,
  input  wire logic                          clock_en,
  // Access port
  input  wire logic                          wr_en,
  input  wire logic [bslc_pkg::clear_aw-1:0] addr,
  input  wire logic [31:0]                   wr_data,
  output logic      [31:0]                   rd_data
);

  logic [31:0] mem [bslc_pkg::clear_words];

  // Read data leaves through a register so the caller sees a clean output.
  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (wr_en) begin
        mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
    end
  end

endmodule : bslc_clr_mem

// ---- src/bslc_pkg.sv ----
// Operation
// - Start loader only when invoked and enabled
// - First interface with connection becomes sole active
// - No connection in window puts device standby
// - Standby left only by power-on reset
// - Loop accepting commands, respond, wait again
// - Start-application command issues system reset
// - No valid command for timeout enters sleep
// - Activity on active interface wakes from sleep
// - Relock before sleep; unlock with password again
// - Timeouts counted on low-frequency clock ticks
// - Fast boot allows only mailbox and application
// - Blank when stack and vector words erased
// - Pin invocation on by default, configurable
// - Checksum mismatch invokes loader or fails boot
// - Host SRAM window ends before stack reserve
// - Buffer spans twice size, capped at twice maximum
// - Clear loader data and stack on exit
// - Fault status word at fixed SRAM location
// - Config checksum code; exception code with index
// - Status readable only when debug access enabled
package bslc_pkg;

  localparam logic [31:0] stat_addr        = 32'h2000_00c0;
  localparam logic [31:0] erased_word      = 32'hffff_ffff;
  localparam logic [31:0] stack_reserve    = 32'h0000_0120;
  localparam logic [15:0] buf_size_max     = 16'hffff;
  localparam logic [7:0]  sw_err_cfg_crc   = 8'h01;
  localparam logic [7:0]  hw_err_nmi       = 8'h07;
  localparam logic [7:0]  cmd_connect      = 8'h12;
  localparam logic [7:0]  cmd_unlock       = 8'h21;
  localparam logic [7:0]  cmd_start_app    = 8'h40;
  // Low-frequency clock runs at 32768 Hz; the timeout is counted in its ticks.
  localparam int          timeout_s        = 10;
  localparam int          low_freq_clock_hz         = 32768;
  localparam int          timeout_ticks    = timeout_s * low_freq_clock_hz;
  localparam int          if_count         = 2;
  localparam int          clear_words      = 64;
  localparam int          clear_aw         = 6;

  // Start-up configuration carried from the non-volatile configuration.
  typedef struct packed {
    logic loader_enable;
    logic fast_boot;
    logic pin_invoke_enable;
    logic crc_check_enable;
    logic debug_access;
    logic pin_level;
  } bslc_cfg_t;

  // Reasons the start-up routine may hand control to the loader.
  typedef struct packed {
    logic app_request;
    logic mailbox;
    logic crc_mismatch;
  } bslc_invoke_t;

  // One command delivered by an interface front end.
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic       pass_ok;
  } bslc_cmd_t;

endpackage : bslc_pkg

// ---- src/bslc_top.sv ----
`timescale 1ns/10ps
module bslc_top (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   clock_en,
  input  wire logic                   por,
  // Configuration and boot inputs
  input  wire bslc_pkg::bslc_cfg_t    cfg,
  input  wire bslc_pkg::bslc_invoke_t invoke,
  input  wire logic [31:0]            stack_word,
  input  wire logic [31:0]            vector_word,
  input  wire logic                   invoke_pin,
  // Timebase
  input  wire logic                   low_freq_tick,
  // Interfaces
  input  wire bslc_pkg::bslc_cmd_t    if_cmd [bslc_pkg::if_count],
  input  wire logic [bslc_pkg::if_count-1:0] if_activity,
  output logic [bslc_pkg::if_count-1:0]      if_enable,
  // Command handshake
  output logic                        cmd_accept,
  output logic [7:0]                  cmd_code,
  input  wire logic                   resp_done,
  // Host memory window
  input  wire logic [31:0]            buf_start,
  input  wire logic [15:0]            buf_size,
  input  wire logic [31:0]            sram_end,
  input  wire logic [31:0]            host_addr,
  output logic                        host_addr_ok,
  output logic                        buf_addr_ok,
  // Fault reporting
  input  wire logic                   cfg_crc_fail,
  input  wire logic                   nmi_event,
  input  wire logic [7:0]             nmi_index,
  input  wire logic                   dbg_rd,
  input  wire logic [31:0]            dbg_addr,
  output logic [31:0]                 dbg_rdata,
  output logic                        dbg_rvalid,
  // Status
  output logic                        loader_active,
  output logic                        unlocked,
  output logic                        standby,
  output logic                        sleeping,
  output logic                        sys_reset,
  output logic                        boot_fail,
  output logic                        clear_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Types and state.

  // Session phases; standby is left only by power-on reset, fail by any reset.
  typedef enum logic [2:0] {
    st_boot,
    st_init,
    st_detect,
    st_command,
    st_sleep,
    st_standby,
    st_clear,
    st_fail
  } bslc_state_t;

  bslc_state_t state;
  bslc_state_t next_state;
  logic [18:0] idle_cnt;
  logic [bslc_pkg::if_count-1:0] active_if;
  logic [bslc_pkg::clear_aw-1:0] clr_addr;
  logic [31:0] fault_word;
  logic        pin_s1;
  logic        pin_s2;
  logic        pend_reset;
  logic        reset_seen;

  // Window arithmetic is done in 33 bits so a sum near the top cannot wrap.
  function automatic logic in_span(input logic [31:0] a, input logic [31:0] lo, input logic [32:0] hi);
    in_span = ({1'b0, a} >= {1'b0, lo}) && ({1'b0, a} < hi);
  endfunction : in_span

  //////////////////////////////////////////////////////////////////////////////
  // Invoke pin synchroniser.

  // The pin is asynchronous to this clock, so it passes two flip-flops.
  // They are not reset: a reset value unlike the pin level would fake an
  // invocation at the first edge after release.
  always_ff @(posedge clock) begin
    if (clock_en) begin
      pin_s1 <= invoke_pin;
      pin_s2 <= pin_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Invocation decode.

  // A checksum mismatch counts only while verification is switched on.
  wire crc_hit    = cfg.crc_check_enable && invoke.crc_mismatch;
  wire blank_dev  = (stack_word == bslc_pkg::erased_word) && (vector_word == bslc_pkg::erased_word);
  wire pin_hit    = cfg.pin_invoke_enable && (pin_s2 == cfg.pin_level);
  wire fast_req   = invoke.mailbox || invoke.app_request;
  wire slow_req   = fast_req || blank_dev || pin_hit || crc_hit;
  wire want_load  = cfg.fast_boot ? fast_req : slow_req;
  wire do_enter   = want_load && cfg.loader_enable;
  // Without the loader a bad application image leaves nothing to run.
  wire fail_boot  = !cfg.fast_boot && crc_hit && !cfg.loader_enable;

  //////////////////////////////////////////////////////////////////////////////
  // Interface selection.

  // Lowest index wins when two interfaces connect in one cycle.
  logic [bslc_pkg::if_count-1:0] conn_hit;
  logic [bslc_pkg::if_count-1:0] first_hit;
  always_comb begin
    first_hit = '0;
    for (int i = 0; i < bslc_pkg::if_count; i++) begin
      conn_hit[i] = if_cmd[i].valid && (if_cmd[i].code == bslc_pkg::cmd_connect);
      if (conn_hit[i] && (first_hit == '0)) begin
        first_hit[i] = 1'b1;
      end
    end
  end

  // Select the command of the active interface.
  bslc_pkg::bslc_cmd_t act_cmd;
  logic                act_wake;
  always_comb begin
    act_cmd  = '0;
    act_wake = 1'b0;
    for (int i = 0; i < bslc_pkg::if_count; i++) begin
      if (active_if[i]) begin
        act_cmd  = if_cmd[i];
        act_wake = if_activity[i];
      end
    end
  end

  // The timeout fires on the tick that completes the count, not one tick later.
  wire any_conn   = |conn_hit;
  wire timed_out  = (idle_cnt >= 19'(bslc_pkg::timeout_ticks - 1)) && low_freq_tick;
  wire cmd_ok     = (state == st_command) && act_cmd.valid;

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencer.

  // Next phase; any phase not moved below holds where it is.
  always_comb begin
    next_state = state;
    case (state)
      st_boot:    next_state = fail_boot ? st_fail : (do_enter ? st_init : st_boot);
      st_init:    next_state = st_detect;
      st_detect:  next_state = any_conn ? st_command : (timed_out ? st_standby : st_detect);
      st_command: begin
        if (cmd_ok && act_cmd.code == bslc_pkg::cmd_start_app) begin
          next_state = st_clear;
        end else if (!cmd_ok && timed_out) begin
          next_state = st_sleep;
        end
      end
      st_sleep:   next_state = act_wake ? st_command : st_sleep;
      st_standby: next_state = st_standby;
      st_clear:   next_state = (clr_addr == '1) ? st_boot : st_clear;
      st_fail:    next_state = st_fail;
      default:    next_state = st_boot;
    endcase
  end

  // Power-on reset is the only exit from standby; a plain reset keeps it.
  always_ff @(posedge clock) begin
    if (reset && por) begin
      state <= st_boot;
    end else if (reset) begin
      state <= (state == st_standby) ? st_standby : st_boot;
    end else if (clock_en) begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Inactivity timer, interface choice and lock.

  // The timer only advances on low-frequency ticks, so both timeouts follow that
  // clock source even when the system clock is changed.
  always_ff @(posedge clock) begin
    if (reset) begin
      idle_cnt <= '0;
    end else if (clock_en) begin
      if (state != next_state || cmd_ok) begin
        idle_cnt <= '0;
      end else if (low_freq_tick) begin
        idle_cnt <= idle_cnt + 19'h1;
      end
    end
  end

  // The interface choice is kept through sleep, so wake activity is looked for
  // only on the interface that opened the session.
  always_ff @(posedge clock) begin
    if (reset) begin
      active_if <= '0;
      unlocked  <= 1'b0;
    end else if (clock_en) begin
      if (state == st_detect && any_conn) begin
        active_if <= first_hit;
      end else if (state == st_boot) begin
        active_if <= '0;
      end
      if (next_state == st_sleep || state == st_boot) begin
        unlocked <= 1'b0;
      end else if (cmd_ok && act_cmd.code == bslc_pkg::cmd_unlock && act_cmd.pass_ok) begin
        unlocked <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scratch clearing on exit.

  // The sweep address walks the scratch memory once; the reset request follows
  // the last write so no loader data survives into the application.
  always_ff @(posedge clock) begin
    if (reset) begin
      clr_addr   <= '0;
      pend_reset <= 1'b0;
      reset_seen <= 1'b0;
    end else if (clock_en) begin
      clr_addr   <= (state == st_clear) ? clr_addr + 1'b1 : '0;
      pend_reset <= (state == st_clear) && (next_state == st_boot);
      reset_seen <= pend_reset;
    end
  end

  // Only the write port is used; the scratch contents are never read back here.
  bslc_clr_mem u_clr_mem (
    .clock    (clock),
    .clock_en (clock_en),
    .wr_en    (state == st_clear),
    .addr     (clr_addr),
    .wr_data  (32'h0000_0000),
    .rd_data  ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Fault status word.

  // Hardware faults are later than configuration faults, so both may stand.
  always_ff @(posedge clock) begin
    if (reset && por) begin
      fault_word <= '0;
    end else if (clock_en) begin
      if (cfg_crc_fail) begin
        fault_word[7:0] <= bslc_pkg::sw_err_cfg_crc;
      end
      if (nmi_event) begin
        fault_word[15:8]  <= nmi_index;
        fault_word[23:16] <= bslc_pkg::hw_err_nmi;
      end
    end
  end

  // Debug reads answer one cycle later; zero when debug access is closed.
  always_ff @(posedge clock) begin
    if (reset) begin
      dbg_rdata  <= '0;
      dbg_rvalid <= 1'b0;
    end else if (clock_en) begin
      dbg_rvalid <= dbg_rd;
      dbg_rdata  <= (dbg_rd && cfg.debug_access && dbg_addr == bslc_pkg::stat_addr) ? fault_word : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host memory window.

  // The packet buffer never exceeds twice the largest size field; the host window
  // stops short of the stack reserve at the top of memory.
  wire [15:0] eff_size = (buf_size > bslc_pkg::buf_size_max) ? bslc_pkg::buf_size_max : buf_size;
  wire [32:0] buf_end  = {1'b0, buf_start} + {16'h0, eff_size, 1'b0};
  wire [32:0] host_end = {1'b0, sram_end} - {1'b0, bslc_pkg::stack_reserve};

  // Both window flags are registered, so they answer one cycle after host_addr.
  always_ff @(posedge clock) begin
    if (reset) begin
      host_addr_ok <= 1'b0;
      buf_addr_ok  <= 1'b0;
    end else if (clock_en) begin
      host_addr_ok <= in_span(host_addr, buf_start, host_end);
      buf_addr_ok  <= in_span(host_addr, buf_start, buf_end);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Phase flags decode the state register; the command handshake is combinational.
  assign cmd_accept    = cmd_ok && resp_done;
  assign cmd_code      = act_cmd.code;
  assign if_enable     = (state == st_detect) ? '1 : active_if;
  assign loader_active = (state == st_init) || (state == st_detect) || (state == st_command) || (state == st_sleep);
  assign standby       = (state == st_standby);
  assign sleeping      = (state == st_sleep);
  assign sys_reset     = reset_seen;
  assign boot_fail     = (state == st_fail);
  assign clear_busy    = (state == st_clear);

endmodule : bslc_top

// ---- tb/bslc_host_model.sv ----
`timescale 1ns/10ps
// Host programmer: hands one whole command to one front end at a time.
module bslc_host_model (
  // Clock
  input wire logic                         clock,
  // Device answers
  input wire logic                         cmd_accept,
  input wire logic [7:0]                   cmd_code,
  // Front-end side
  output bslc_pkg::bslc_cmd_t              if_cmd [bslc_pkg::if_count],
  output logic [bslc_pkg::if_count-1:0]    if_activity
);
  logic       acc_seen;
  logic [7:0] code_seen;
  // Idle front ends show a changing code so a stale value is never mistaken for data.
  initial begin
    foreach (if_cmd[i]) if_cmd[i] = '{valid: 1'b0, code: 8'h00, pass_ok: 1'b0};
    if_activity = '0;
  end
  // Activity travels with each command, which is also what wakes a sleeping loader.
  task automatic send(input int i, input logic [7:0] c);
    @(posedge clock);
    if_cmd[i] <= '{valid: 1'b1, code: c, pass_ok: 1'b1};
    if_activity[i] <= 1'b1;
    @(negedge clock);
    acc_seen = cmd_accept;
    code_seen = cmd_code;
    @(posedge clock);
    if_cmd[i] <= '{valid: 1'b0, code: ~c, pass_ok: 1'b0};
    if_activity[i] <= 1'b0;
    // Return where the device's answer to the command has settled.
    @(negedge clock);
  endtask : send
endmodule : bslc_host_model

// ---- tb/bslc_top_monitor.sv ----
`timescale 1ns/10ps
// Port-level checks on the loader sequencer; one clock domain.
module bslc_top_monitor (
  // Clock and reset
  input wire logic                            clock,
  input wire logic                            reset,
  input wire logic                            por,
  // Debug read
  input wire logic                            dbg_rd,
  input wire logic [31:0]                     dbg_addr,
  input wire logic [31:0]                     dbg_rdata,
  input wire logic                            dbg_rvalid,
  // Host window
  input wire logic [31:0]                     host_addr,
  input wire logic [31:0]                     buf_start,
  input wire logic [31:0]                     sram_end,
  input wire logic                            host_addr_ok,
  // Session state
  input wire logic                            cmd_accept,
  input wire logic [bslc_pkg::if_count-1:0]   if_enable,
  input wire logic                            loader_active,
  input wire logic                            unlocked,
  input wire logic                            standby,
  input wire logic                            sleeping,
  input wire logic                            sys_reset,
  input wire logic                            boot_fail,
  input wire logic                            clear_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  //////////////////////////////
  // Exit path: the sweep must finish before the reset pulse leaves.
  chk_reset_pulse: assert property (sys_reset |=> !sys_reset)
    else $error("sys_reset wider than one cycle");
  chk_clear_first: assert property ($rose(sys_reset) |-> $past(clear_busy, 2))
    else $error("sys_reset without a preceding sweep");
  // Commands only arrive through one interface while the loader runs.
  chk_accept_sole: assert property (cmd_accept |-> $onehot(if_enable) && loader_active)
    else $error("command taken without a sole active interface");
  chk_standby_hold: assert property (standby && !por |=> standby)
    else $error("standby left without power-on reset");
  chk_sleep_locked: assert property (sleeping |-> !unlocked)
    else $error("sleeping while unlocked");
  chk_fail_idle: assert property (boot_fail |-> !loader_active)
    else $error("boot failure with loader running");
  // Debug reads answer next cycle and only the status word may be nonzero.
  chk_dbg_answer: assert property (dbg_rd |=> dbg_rvalid)
    else $error("debug read not answered");
  chk_dbg_gate: assert property (dbg_rvalid && dbg_rdata != 0 |-> $past(dbg_addr) == bslc_pkg::stat_addr)
    else $error("nonzero debug data off the status word");
  chk_host_span: assert property (host_addr_ok |->
    $past(host_addr) >= $past(buf_start) && $past(host_addr) <= $past(sram_end) - bslc_pkg::stack_reserve)
    else $error("host address accepted outside its window");
  cov_reset: cover property (sys_reset);
  cov_accept: cover property (cmd_accept);
  cov_status: cover property (dbg_rvalid && dbg_rdata != 0);
endmodule : bslc_top_monitor

// ---- tb/test_boot_loader_session_control.sv ----
`timescale 1ns/10ps
module test_boot_loader_session_control;
  logic clock = 1'b0, reset = 1'b1, clock_en = 1'b1, por = 1'b1;
  bslc_pkg::bslc_cfg_t cfg = '0;
  bslc_pkg::bslc_invoke_t invoke = '0;
  logic [31:0] stack_word = 32'hffff_ffff, vector_word = 32'hffff_ffff, dbg_addr = '0, dbg_rdata;
  logic [31:0] buf_start = 32'h2000_1000, sram_end = 32'h2000_8000, host_addr = '0;
  logic [15:0] buf_size = 16'h0100;
  logic invoke_pin = 1'b0, low_freq_tick = 1'b0, resp_done = 1'b1;
  logic cfg_crc_fail = 1'b0, nmi_event = 1'b0, dbg_rd = 1'b0;
  logic [7:0] nmi_index = 8'h00, cmd_code;
  bslc_pkg::bslc_cmd_t if_cmd [bslc_pkg::if_count];
  logic [bslc_pkg::if_count-1:0] if_activity, if_enable;
  logic cmd_accept, host_addr_ok, buf_addr_ok, dbg_rvalid, loader_active, unlocked;
  logic standby, sleeping, sys_reset, boot_fail, clear_busy;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, busy = 0;
  // Entry table: cfg, invoke, blank, pin, expect active, expect fail.
  localparam logic [12:0] rows [11] = '{13'h0008, 13'h1842, 13'h1c84, 13'h1486, 13'h1084,
    13'h1212, 13'h0211, 13'h1822, 13'h1402, 13'h1404, 13'h1010};
  initial forever #5 clock = ~clock;
  // The tick only exercises the timebase; a full ten-second wait is far beyond this run.
  always @(posedge clock) begin
    low_freq_tick <= (cyc % 16 == 0);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end
  always @(negedge clock) if (clear_busy === 1'b1) busy++;
  bslc_top i_dut (.clock, .reset, .clock_en, .por, .cfg, .invoke, .stack_word, .vector_word, .invoke_pin,
    .low_freq_tick, .if_cmd, .if_activity, .if_enable, .cmd_accept, .cmd_code, .resp_done, .buf_start,
    .buf_size, .sram_end, .host_addr, .host_addr_ok, .buf_addr_ok, .cfg_crc_fail, .nmi_event, .nmi_index,
    .dbg_rd, .dbg_addr, .dbg_rdata, .dbg_rvalid, .loader_active, .unlocked, .standby, .sleeping,
    .sys_reset, .boot_fail, .clear_busy);
  bslc_host_model i_host (.clock, .cmd_accept, .cmd_code, .if_cmd, .if_activity);
  //////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  // Power-on reset, then a bounded wait for the start-up routine to decide.
  task automatic reboot(input int n);
    @(posedge clock);
    reset <= 1'b1;
    por <= 1'b1;
    repeat (n) @(posedge clock);
    reset <= 1'b0;
    por <= 1'b0;
    for (int k = 0; k < 20 && loader_active !== 1'b1 && boot_fail !== 1'b1; k++) @(negedge clock);
  endtask : reboot
  task automatic t_session;
    cfg <= 6'h22;
    reboot(12);
    cmp(loader_active, 1'b1, "blank entry");
    @(negedge clock);
    cmp(if_enable, 2'h3, "detect polls all");
    cmp(standby, 1'b0, "no standby while detecting");
    cmp(sleeping, 1'b0, "awake while detecting");
    i_host.send(1, bslc_pkg::cmd_connect);
    cmp(if_enable, 2'h2, "sole active");
    i_host.send(0, bslc_pkg::cmd_unlock);
    cmp(i_host.acc_seen, 1'b0, "disabled interface");
    i_host.send(1, bslc_pkg::cmd_unlock);
    cmp(i_host.acc_seen, 1'b1, "command taken");
    cmp(i_host.code_seen, bslc_pkg::cmd_unlock, "command code");
    cmp(unlocked, 1'b1, "unlock");
    @(posedge clock) resp_done <= 1'b0;
    i_host.send(1, 8'h19);
    cmp(i_host.acc_seen, 1'b0, "response pending");
    @(posedge clock) resp_done <= 1'b1;
    i_host.send(1, 8'h19);
    cmp(i_host.acc_seen, 1'b1, "next command");
  endtask : t_session
  task automatic dbg_read(input logic [31:0] a, input logic on, input logic [31:0] exp);
    @(posedge clock);
    cfg.debug_access <= on;
    dbg_rd <= 1'b1;
    dbg_addr <= a;
    @(posedge clock);
    dbg_rd <= 1'b0;
    @(negedge clock);
    cmp(dbg_rvalid, 1'b1, "read answered");
    cmp(dbg_rdata, exp, "read data");
  endtask : dbg_read
  // Both fault kinds land in one word; only the status address with debug on shows it.
  task automatic t_fault;
    @(posedge clock);
    cfg_crc_fail <= 1'b1;
    nmi_event <= 1'b1;
    nmi_index <= 8'h5a;
    @(posedge clock);
    cfg_crc_fail <= 1'b0;
    nmi_event <= 1'b0;
    dbg_read(bslc_pkg::stat_addr, 1'b1, 32'h0007_5a01);
    dbg_read(32'h2000_00c4, 1'b1, 32'h0000_0000);
    dbg_read(bslc_pkg::stat_addr, 1'b0, 32'h0000_0000);
  endtask : t_fault
  task automatic win(input logic [31:0] a, input logic h, input logic b);
    @(posedge clock);
    host_addr <= a;
    @(posedge clock);
    @(negedge clock);
    cmp(host_addr_ok, h, "host window");
    cmp(buf_addr_ok, b, "buffer window");
  endtask : win
  task automatic t_window;
    win(32'h2000_0fff, 1'b0, 1'b0);
    win(32'h2000_1000, 1'b1, 1'b1);
    win(32'h2000_11ff, 1'b1, 1'b1);
    win(32'h2000_1200, 1'b1, 1'b0);
    win(32'h2000_7edf, 1'b1, 1'b0);
    win(32'h2000_7ee1, 1'b0, 1'b0);
  endtask : t_window
  task automatic t_start_app;
    busy = 0;
    i_host.send(1, bslc_pkg::cmd_start_app);
    for (int k = 0; k < 200 && sys_reset !== 1'b1; k++) @(negedge clock);
    cmp(busy, bslc_pkg::clear_words, "sweep length");
    cmp(sys_reset, 1'b1, "system reset");
  endtask : t_start_app
  task automatic t_invoke;
    for (int r = 0; r < 11; r++) begin
      @(posedge clock);
      cfg <= rows[r][12:7];
      invoke <= rows[r][6:4];
      stack_word <= rows[r][3] ? 32'hffff_ffff : 32'h2000_4000;
      invoke_pin <= rows[r][2];
      reboot(2);
      cmp(loader_active, rows[r][1], "entry decision");
      cmp(boot_fail, rows[r][0], "boot failure");
    end
  endtask : t_invoke
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    t_session();
    t_fault();
    t_window();
    t_start_app();
    t_invoke();
    tally_and_finish();
  end
endmodule : test_boot_loader_session_control
bind bslc_top bslc_top_monitor i_mon (.clock, .reset, .por, .dbg_rd, .dbg_addr, .dbg_rdata, .dbg_rvalid,
  .host_addr, .buf_start, .sram_end, .host_addr_ok, .cmd_accept, .if_enable, .loader_active, .unlocked,
  .standby, .sleeping, .sys_reset, .boot_fail, .clear_busy);
